// File: verilog/ubcm_consts.svh
// register offsets, field positions and reset values of the break-match block
`ifndef UBCM_CONSTS_SVH
`define UBCM_CONSTS_SVH
`define UBCM_OFF_A_ADDR   8'h00
`define UBCM_OFF_A_MASK   8'h04
`define UBCM_OFF_A_CYC    8'h08
`define UBCM_OFF_A_ASID   8'h0c
`define UBCM_OFF_B_ADDR   8'h10
`define UBCM_OFF_B_MASK   8'h14
`define UBCM_OFF_B_CYC    8'h18
`define UBCM_OFF_B_ASID   8'h1c
`define UBCM_OFF_B_VAL    8'h20
`define UBCM_OFF_B_VMASK  8'h24
`define UBCM_OFF_CTRL     8'h28
`define UBCM_OFF_FLAGS    8'h2c
`define UBCM_OFF_COUNT    8'h30
`define UBCM_CD_LSB       6
`define UBCM_ID_LSB       4
`define UBCM_RW_LSB       2
`define UBCM_SZ_LSB       0
`define UBCM_CTL_SEQ      0
`define UBCM_CTL_POST_A   1
`define UBCM_CTL_POST_B   2
`define UBCM_CTL_DATA_EN  3
`define UBCM_CTL_ASID_A   4
`define UBCM_CTL_ASID_B   5
`define UBCM_CTL_BUS_SEL  6
`define UBCM_FLG_CPU_A    0
`define UBCM_FLG_CPU_B    1
`define UBCM_FLG_DMA_A    2
`define UBCM_FLG_DMA_B    3
`define UBCM_RST_WORD     32'h0000_0000
`define UBCM_RST_CYC      16'h0000
`define UBCM_RST_CTRL     7'h00
`define UBCM_RST_COUNT    16'h0001
`define UBCM_RESP_OKAY    2'h0
`define UBCM_RESP_SLVERR  2'h2
`endif

// File: verilog/ubcm_pkg.sv
// types shared by the break-match block
package ubcm_pkg;
  typedef enum logic [1:0] {
    UBCM_SZ_NONE = 2'h0,
    UBCM_SZ_BYTE = 2'h1,
    UBCM_SZ_WORD = 2'h2,
    UBCM_SZ_LONG = 2'h3
  } ubcm_size_t;
  typedef enum logic [1:0] {
    UBCM_BRK_PRE  = 2'h0,
    UBCM_BRK_POST = 2'h1,
    UBCM_BRK_DATA = 2'h3
  } ubcm_brk_t;
  typedef enum logic [1:0] {
    UBCM_SEQ_IDLE  = 2'h0,
    UBCM_SEQ_ARMED = 2'h1
  } ubcm_seq_t;
endpackage

// File: verilog/ubcm_chan_cmp.sv
// condition comparator of one break channel
`timescale 1ns/1ns
`include "ubcm_consts.svh"
module ubcm_chan_cmp #(
  parameter bit HAS_DATA = 1'b0
) (
  input  wire logic [31:0] brk_addr_i,
  input  wire logic [31:0] addr_mask_i,
  input  wire logic [15:0] cyc_sel_i,
  input  wire logic [7:0]  asid_i,
  input  wire logic        asid_en_i,
  input  wire logic        data_en_i,
  input  wire logic [31:0] brk_val_i,
  input  wire logic [31:0] val_mask_i,
  input  wire logic        cyc_valid_i,
  input  wire logic        cyc_dma_i,
  input  wire logic        cyc_fetch_i,
  input  wire logic        cyc_write_i,
  input  wire logic        cyc_from_insn_i,
  input  wire logic [1:0]  cyc_size_i,
  input  wire logic [31:0] cyc_addr_i,
  input  wire logic [31:0] cyc_data_i,
  input  wire logic [7:0]  cyc_asid_i,
  output logic             hit_o
);
  logic [1:0]  cd, id, rw, sz;
  logic [31:0] low_ign;
  logic [15:0] lane;
  logic        grp_ok, kind_ok, size_ok, addr_ok, asid_ok, data_ok;

  assign cd = cyc_sel_i[`UBCM_CD_LSB +: 2];
  assign id = cyc_sel_i[`UBCM_ID_LSB +: 2];
  assign rw = cyc_sel_i[`UBCM_RW_LSB +: 2];
  assign sz = cyc_sel_i[`UBCM_SZ_LSB +: 2];

  assign grp_ok = (|cd) & (|id) & (|rw); // R02
  // fetches reach us only when confirmed for execution, so overruns never match
  assign kind_ok = (cyc_dma_i ? cd[1] : (cd[0] & (cyc_fetch_i | cyc_from_insn_i))) // R13 R07 R10
                 & (cyc_fetch_i ? (id[0] & ~cyc_write_i) : id[1])                  // R06
                 & (cyc_write_i ? rw[1] : rw[0]);
  assign size_ok = cyc_fetch_i ? (sz != ubcm_pkg::UBCM_SZ_BYTE)                     // R06
                 : ((sz == ubcm_pkg::UBCM_SZ_NONE) || (sz == cyc_size_i));

  always_comb begin
    low_ign = 32'h0000_0000;
    if (!cyc_fetch_i) begin
      if (cyc_size_i == ubcm_pkg::UBCM_SZ_LONG) begin
        low_ign = 32'h0000_0003; // R14
      end else if (cyc_size_i == ubcm_pkg::UBCM_SZ_WORD) begin
        low_ign = 32'h0000_0001; // R14
      end
    end
  end
  assign addr_ok = ((brk_addr_i ^ cyc_addr_i) & ~addr_mask_i & ~low_ign) == 32'h0; // R21
  assign asid_ok = ~asid_en_i | (asid_i == cyc_asid_i);                             // R22

  // big-endian lanes: even byte address sits in bits 15-8
  assign lane = (cyc_size_i == ubcm_pkg::UBCM_SZ_BYTE)
              ? (cyc_addr_i[0] ? 16'h00ff : 16'hff00) : 16'hffff;
  always_comb begin
    if (!HAS_DATA || !data_en_i || cyc_fetch_i) begin
      data_ok = 1'b1; // R12
    end else if (sz == ubcm_pkg::UBCM_SZ_NONE) begin
      data_ok = 1'b0; // R15
    end else if (cyc_size_i == ubcm_pkg::UBCM_SZ_LONG) begin
      data_ok = ((brk_val_i ^ cyc_data_i) & ~val_mask_i) == 32'h0; // R21
    end else begin
      data_ok = ((brk_val_i[15:0] ^ cyc_data_i[15:0]) & ~val_mask_i[15:0] & lane) == 16'h0; // R16
    end
  end

  assign hit_o = cyc_valid_i & grp_ok & kind_ok & size_ok & addr_ok & asid_ok & data_ok; // R15
endmodule

// File: verilog/ubcm_top.sv
// break-condition match unit with an AXI4-Lite register slave
//
// Overview of operation
// R01: channel B ASID register, 8 bits, unreset
// R02: a CD, ID or RW bus-cycle group at 00 blocks breaks
// R03: match sends break request plus break type
// R04: sticky CPU/DMA match flags, cleared by writing 0
// R05: near-simultaneous breaks give one request only
// R06: CPU fetch read word/long is fetch break
// R07: pre-execution fetch break ignores overrun fetches
// R08: delay-slot break taken at next accepting instruction
// R09: software avoids delay-slot pre and sleep post
// R10: post-execution break follows completed instruction
// R11: delayed-branch post break at next accepting instruction
// R12: channel B data ignored for fetch cycles
// R13: CPU data breaks only from instruction accesses
// R14: address compare width follows access size
// R15: data condition needs size, address and data
// R16: word/byte data ignores bits 31-16
// R17: software limits DMA operand size settings
// R18: sequential mode: B counts only after A
// R19: simultaneous A and B gives no sequential break
// R20: sequential bus select and execution count
// R21: set mask bits exclude bits from compare
// R22: enabled ASID check requires equal ASID
`timescale 1ns/1ns
`include "ubcm_consts.svh"
module ubcm_top (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cyc_valid_i,
  input  wire logic        cyc_dma_i,
  input  wire logic        cyc_fetch_i,
  input  wire logic        cyc_write_i,
  input  wire logic        cyc_from_insn_i,
  input  wire logic [1:0]  cyc_size_i,
  input  wire logic [31:0] cyc_laddr_i,
  input  wire logic [31:0] cyc_iaddr_i,
  input  wire logic [31:0] cyc_data_i,
  input  wire logic [7:0]  cyc_asid_i,
  input  wire logic        cpu_accept_i,
  input  wire logic        brk_ack_i,
  output logic             brk_req_o,
  output logic [1:0]       brk_type_o
);
  // ==========================================================================
  // register bus
  logic [31:0] brk_addr_q  [2];
  logic [31:0] addr_mask_q [2];
  logic [15:0] cyc_sel_q   [2];
  logic [7:0]  asid_q      [2];
  logic [31:0] brk_val_q, val_mask_q;
  logic [6:0]  ctrl_q;
  logic [15:0] count_q;
  logic [3:0]  flags_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q, wmask, rd_word;
  logic        wr_go, rd_hit, wr_hit, flag_wr;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go = aw_held_q & w_held_q;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign flag_wr = wr_go & (aw_addr_q == `UBCM_OFF_FLAGS);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= `UBCM_RST_WORD;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (aw_addr_q)
      `UBCM_OFF_A_ADDR, `UBCM_OFF_A_MASK, `UBCM_OFF_A_CYC, `UBCM_OFF_A_ASID,
      `UBCM_OFF_B_ADDR, `UBCM_OFF_B_MASK, `UBCM_OFF_B_CYC, `UBCM_OFF_B_ASID,
      `UBCM_OFF_B_VAL, `UBCM_OFF_B_VMASK, `UBCM_OFF_CTRL, `UBCM_OFF_FLAGS,
      `UBCM_OFF_COUNT: wr_hit = 1'b1;
      default:         wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `UBCM_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `UBCM_RESP_OKAY : `UBCM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ASID registers carry no reset: their content is undefined until written
  always_ff @(posedge clk_i) begin
    if (wr_go && aw_addr_q == `UBCM_OFF_A_ASID && w_strb_q[0]) begin
      asid_q[0] <= w_data_q[7:0];
    end
    if (wr_go && aw_addr_q == `UBCM_OFF_B_ASID && w_strb_q[0]) begin
      asid_q[1] <= w_data_q[7:0]; // R01
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      brk_addr_q  <= '{`UBCM_RST_WORD, `UBCM_RST_WORD};
      addr_mask_q <= '{`UBCM_RST_WORD, `UBCM_RST_WORD};
      cyc_sel_q   <= '{`UBCM_RST_CYC, `UBCM_RST_CYC};
      brk_val_q   <= `UBCM_RST_WORD;
      val_mask_q  <= `UBCM_RST_WORD;
      ctrl_q      <= `UBCM_RST_CTRL;
      count_q     <= `UBCM_RST_COUNT;
    end else if (wr_go) begin
      unique case (aw_addr_q)
        `UBCM_OFF_A_ADDR:  brk_addr_q[0]  <= (brk_addr_q[0] & ~wmask) | (w_data_q & wmask);
        `UBCM_OFF_A_MASK:  addr_mask_q[0] <= (addr_mask_q[0] & ~wmask) | (w_data_q & wmask);
        `UBCM_OFF_A_CYC:   cyc_sel_q[0]   <= (cyc_sel_q[0] & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        `UBCM_OFF_B_ADDR:  brk_addr_q[1]  <= (brk_addr_q[1] & ~wmask) | (w_data_q & wmask);
        `UBCM_OFF_B_MASK:  addr_mask_q[1] <= (addr_mask_q[1] & ~wmask) | (w_data_q & wmask);
        `UBCM_OFF_B_CYC:   cyc_sel_q[1]   <= (cyc_sel_q[1] & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        `UBCM_OFF_B_VAL:   brk_val_q      <= (brk_val_q & ~wmask) | (w_data_q & wmask);
        `UBCM_OFF_B_VMASK: val_mask_q     <= (val_mask_q & ~wmask) | (w_data_q & wmask);
        `UBCM_OFF_CTRL:    ctrl_q         <= w_strb_q[0] ? w_data_q[6:0] : ctrl_q;
        `UBCM_OFF_COUNT:   count_q        <= (count_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        default:           ctrl_q         <= ctrl_q;
      endcase
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'h0})
      `UBCM_OFF_A_ADDR:  rd_word = brk_addr_q[0];
      `UBCM_OFF_A_MASK:  rd_word = addr_mask_q[0];
      `UBCM_OFF_A_CYC:   rd_word = {16'h0000, cyc_sel_q[0]};
      `UBCM_OFF_A_ASID:  rd_word = {24'h00_0000, asid_q[0]};
      `UBCM_OFF_B_ADDR:  rd_word = brk_addr_q[1];
      `UBCM_OFF_B_MASK:  rd_word = addr_mask_q[1];
      `UBCM_OFF_B_CYC:   rd_word = {16'h0000, cyc_sel_q[1]};
      `UBCM_OFF_B_ASID:  rd_word = {24'h00_0000, asid_q[1]};
      `UBCM_OFF_B_VAL:   rd_word = brk_val_q;
      `UBCM_OFF_B_VMASK: rd_word = val_mask_q;
      `UBCM_OFF_CTRL:    rd_word = {25'h000_0000, ctrl_q};
      `UBCM_OFF_FLAGS:   rd_word = {28'h000_0000, flags_q};
      `UBCM_OFF_COUNT:   rd_word = {16'h0000, count_q};
      default:           rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= `UBCM_RST_WORD;
      rresp_q  <= `UBCM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? `UBCM_RESP_OKAY : `UBCM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // channel comparators
  logic [1:0]  hit;
  logic [31:0] cyc_addr;
  logic        seq_mode;
  assign seq_mode = ctrl_q[`UBCM_CTL_SEQ];
  assign cyc_addr = ctrl_q[`UBCM_CTL_BUS_SEL] ? cyc_iaddr_i : cyc_laddr_i; // R20

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    ubcm_chan_cmp #(
      .HAS_DATA (ch == 1)
    ) u_cmp (
      .brk_addr_i      (brk_addr_q[ch]),
      .addr_mask_i     (addr_mask_q[ch]),
      .cyc_sel_i       (cyc_sel_q[ch]),
      .asid_i          (asid_q[ch]),
      .asid_en_i       (ctrl_q[`UBCM_CTL_ASID_A + ch]),
      .data_en_i       (ctrl_q[`UBCM_CTL_DATA_EN]),
      .brk_val_i       (brk_val_q),
      .val_mask_i      (val_mask_q),
      .cyc_valid_i     (cyc_valid_i),
      .cyc_dma_i       (cyc_dma_i),
      .cyc_fetch_i     (cyc_fetch_i),
      .cyc_write_i     (cyc_write_i),
      .cyc_from_insn_i (cyc_from_insn_i),
      .cyc_size_i      (cyc_size_i),
      .cyc_addr_i      (cyc_addr),
      .cyc_data_i      (cyc_data_i),
      .cyc_asid_i      (cyc_asid_i),
      .hit_o           (hit[ch])
    );
  end

  // ==========================================================================
  // sticky match flags: a hit in the clearing cycle wins over the clear
  logic [3:0] flag_set;
  assign flag_set = {hit[1] & cyc_dma_i, hit[0] & cyc_dma_i,
                     hit[1] & ~cyc_dma_i, hit[0] & ~cyc_dma_i};
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= flag_set | (flags_q & ~(flag_wr & w_strb_q[0] ? ~w_data_q[3:0] : 4'h0)); // R04
    end
  end

  // ==========================================================================
  // sequential mode
  ubcm_pkg::ubcm_seq_t seq_q;
  logic [15:0] remain_q;
  logic        seq_fire, fire;
  assign seq_fire = seq_mode & (seq_q == ubcm_pkg::UBCM_SEQ_ARMED) & hit[1] & ~hit[0]
                  & (remain_q <= 16'h0001); // R18 R19 R20
  assign fire = seq_mode ? seq_fire : (|hit);

  always_ff @(posedge clk_i) begin
    if (srst_i || !seq_mode) begin
      seq_q    <= ubcm_pkg::UBCM_SEQ_IDLE;
      remain_q <= `UBCM_RST_COUNT;
    end else if (hit[0]) begin
      seq_q    <= ubcm_pkg::UBCM_SEQ_ARMED; // R19
      remain_q <= count_q;
    end else if (hit[1]) begin
      unique case (seq_q)
        ubcm_pkg::UBCM_SEQ_IDLE: seq_q <= ubcm_pkg::UBCM_SEQ_IDLE; // R18
        ubcm_pkg::UBCM_SEQ_ARMED: begin
          if (seq_fire) begin
            seq_q <= ubcm_pkg::UBCM_SEQ_IDLE;
          end else begin
            remain_q <= remain_q - 16'h0001; // R20
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // break request toward the interrupt controller
  logic                pend_q, take;
  logic                src_ch;
  ubcm_pkg::ubcm_brk_t type_d, type_q;
  assign src_ch = seq_mode | ~hit[0];
  always_comb begin
    if (!cyc_fetch_i) begin
      type_d = ubcm_pkg::UBCM_BRK_DATA;
    end else if (ctrl_q[`UBCM_CTL_POST_A + src_ch]) begin
      type_d = ubcm_pkg::UBCM_BRK_POST; // R10
    end else begin
      type_d = ubcm_pkg::UBCM_BRK_PRE; // R07
    end
  end

  // presented only where the CPU can accept it, which skips delay slots
  assign brk_req_o  = pend_q & cpu_accept_i; // R08 R11
  assign take       = brk_req_o & brk_ack_i;
  assign brk_type_o = type_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend_q <= 1'b0;
      type_q <= ubcm_pkg::UBCM_BRK_PRE;
    end else if (fire && (!pend_q || take)) begin // R05
      pend_q <= 1'b1; // R03
      type_q <= type_d;
    end else if (take) begin
      pend_q <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_armed_b;
    seq_mode && seq_q == ubcm_pkg::UBCM_SEQ_ARMED && remain_q == 16'h0001 && hit[1] && !hit[0];
  endsequence
  sequence s_fired_back_idle;
    brk_req_o || pend_q ##0 seq_q == ubcm_pkg::UBCM_SEQ_IDLE;
  endsequence

  a_group_zero: assert property (cyc_sel_q[0][`UBCM_CD_LSB +: 2] == 2'h0 |-> !hit[0]) // R02
    else $error("channel A hit with cycle group zero");
  a_req_type: assert property (fire && !pend_q |=> pend_q && brk_type_o == $past(type_d)) // R03
    else $error("break not pending with its type");
  a_flag_sticky: assert property (flags_q[0] && !flag_wr |=> flags_q[0]) // R04
    else $error("match flag dropped without a write");
  a_single_req: assert property (pend_q && !take |=> pend_q && $stable(brk_type_o)) // R05
    else $error("pending break replaced before taken");
  a_accept_gate: assert property (!cpu_accept_i |-> !brk_req_o) // R08
    else $error("break offered at a non-accepting boundary");
  a_insn_data: assert property (cyc_valid_i && !cyc_dma_i && !cyc_fetch_i && !cyc_from_insn_i
                                |-> hit == 2'b00) // R13
    else $error("data break from non-instruction cycle");
  a_seq_early_b: assert property (seq_mode && seq_q == ubcm_pkg::UBCM_SEQ_IDLE |-> !fire) // R18
    else $error("sequential break before channel A");
  a_seq_same: assert property (seq_mode && hit[0] && hit[1] |-> !fire) // R19
    else $error("sequential break on simultaneous match");
  a_seq_count: assert property (s_armed_b |=> s_fired_back_idle) // R20
    else $error("count of one did not break");
endmodule

// File: dv/ubcm_cpu_model.sv
// far-side model: interrupt controller acknowledge and cpu break-acceptance window
`timescale 1ns/1ns
module ubcm_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       brk_req_i,
  input  wire logic       slot_i,
  input  wire logic       slow_i,
  output logic            accept_o,
  output logic            ack_o,
  output logic [7:0]      taken_o
);
  logic [1:0] wait_q;
  // ====================================
  // instruction boundary
  // a delay slot refuses breaks, so a pending request waits for the next boundary
  assign accept_o = !slot_i;
  // ====================================
  // acknowledge
  // slow mode lets the request stand a few cycles so that later matches must merge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_o   <= 1'b0;
      wait_q  <= 2'h0;
      taken_o <= 8'h00;
    end else begin
      wait_q <= brk_req_i ? wait_q + 2'h1 : 2'h0;
      ack_o  <= brk_req_i && !ack_o && (!slow_i || wait_q == 2'h3);
      if (brk_req_i && ack_o) begin
        taken_o <= taken_o + 8'h01;
      end
    end
  end
endmodule

// File: dv/ubcm_bench.sv
// self-checking bench of the break-condition match unit
`timescale 1ns/1ns
`include "ubcm_consts.svh"
module user_break_condition_match_bench;
  logic        clk_i = 1'b0, srst_i = 1'b1, slot = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, cyc_asid_i = '0, n0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, cyc_valid_i = '0, cyc_dma_i = '0;
  logic        cyc_fetch_i = '0, cyc_write_i = '0, cyc_from_insn_i = '0;
  logic [31:0] s_axi_wdata = '0, cyc_laddr_i = '0, cyc_iaddr_i = '0, cyc_data_i = '0, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  cyc_size_i = '0, rsp;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   cpu_accept_i, brk_ack_i, brk_req_o;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp, brk_type_o;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0]  taken;
  int          error_cnt = 0, check_count = 0, cycles = 0;
  ubcm_top i_dut (.clk_i, .srst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cyc_valid_i, .cyc_dma_i, .cyc_fetch_i, .cyc_write_i, .cyc_from_insn_i,
    .cyc_size_i, .cyc_laddr_i, .cyc_iaddr_i, .cyc_data_i, .cyc_asid_i, .cpu_accept_i,
    .brk_ack_i, .brk_req_o, .brk_type_o);
  ubcm_cpu_model i_cpu (.clk_i, .srst_i, .brk_req_i(brk_req_o), .slot_i(slot), .slow_i(slow),
    .accept_o(cpu_accept_i), .ack_o(brk_ack_i), .taken_o(taken));
  // ====================================
  // clock, watchdog, verdict
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ====================================
  // bus tasks: sampled mid-cycle so the edge sees the same settled handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_i);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ar, r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_i);
      ar = s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk_i);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask
  // channel a at base 00, channel b at base 10: same layout
  task automatic setch(input logic [7:0] b, input logic [31:0] a, m, input logic [7:0] c);
    wr(b, a);
    wr(b + 8'h04, m);
    wr(b + 8'h08, {24'h0, c});
  endtask
  // k = {dma, fetch, write, from_insn, size[1:0]}; idle lines carry inverted values
  task automatic cyc(input logic [5:0] k, input logic [31:0] a, d, input logic [7:0] id);
    {cyc_dma_i, cyc_fetch_i, cyc_write_i, cyc_from_insn_i, cyc_size_i} <= k;
    cyc_valid_i <= 1'b1;
    cyc_laddr_i <= a;
    cyc_iaddr_i <= ~a;
    cyc_data_i <= d;
    cyc_asid_i <= id;
    @(posedge clk_i);
    cyc_valid_i <= 1'b0;
    cyc_laddr_i <= ~a;
    cyc_data_i <= ~d;
  endtask
  task automatic fire(input logic [5:0] k, input logic [31:0] a, d, input logic [7:0] id, n);
    n0 = taken;
    cyc(k, a, d, id);
    repeat (8) @(posedge clk_i);
    check(taken - n0, n);
  endtask
  // ====================================
  // scenarios
  task automatic t_regs();
    wr(`UBCM_OFF_B_ASID, 32'hffff_ff5a);
    wr(`UBCM_OFF_COUNT, 32'h0000_0005);
    // reset spares the ASID
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rdr(`UBCM_OFF_B_ASID);
    check(rd[7:0], 8'h5a);
    rdr(`UBCM_OFF_COUNT);
    check(rd, 32'h0000_0001);
    rdr(8'h3c);
    check(rsp, `UBCM_RESP_SLVERR);
    wr(8'h3c, 32'h0000_0001);
    check(rsp, `UBCM_RESP_SLVERR);
    $display("t_regs done");
  endtask
  task automatic t_fetch();
    logic [7:0] cs[4] = '{8'h17, 8'h47, 8'h53, 8'h55};
    setch(8'h00, 32'h0000_0404, 32'h0, 8'h57);
    fire(6'h17, 32'h0000_0404, 32'h0, 8'h00, 8'h01);
    check(brk_type_o, ubcm_pkg::UBCM_BRK_PRE);
    rdr(`UBCM_OFF_FLAGS);
    check(rd[3:0], 4'h1);
    fire(6'h17, 32'h0000_0408, 32'h0, 8'h00, 8'h00);
    wr(`UBCM_OFF_CTRL, 32'h0000_0002);
    slow <= 1'b1;
    fire(6'h17, 32'h0000_0404, 32'h0, 8'h00, 8'h01);
    check(brk_type_o, ubcm_pkg::UBCM_BRK_POST);
    wr(`UBCM_OFF_A_MASK, 32'h0000_000c);
    fire(6'h17, 32'h0000_0408, 32'h0, 8'h00, 8'h01);
    wr(`UBCM_OFF_CTRL, 32'h0000_0010);
    wr(`UBCM_OFF_A_ASID, 32'h0000_0080);
    fire(6'h17, 32'h0000_0404, 32'h0, 8'h70, 8'h00);
    fire(6'h17, 32'h0000_0404, 32'h0, 8'h80, 8'h01);
    wr(`UBCM_OFF_FLAGS, 32'h0);
    rdr(`UBCM_OFF_FLAGS);
    check(rd[3:0], 4'h0);
    foreach (cs[i]) begin
      wr(`UBCM_OFF_A_CYC, {24'h0, cs[i]});
      fire(6'h17, 32'h0000_0404, 32'h0, 8'h80, 8'h00);
    end
    setch(8'h00, 32'h0000_0500, 32'h0, 8'ha8);
    fire(6'h2b, 32'h0000_0500, 32'h0, 8'h80, 8'h01);
    check(brk_type_o, ubcm_pkg::UBCM_BRK_DATA);
    rdr(`UBCM_OFF_FLAGS);
    check(rd[3:0], 4'h4);
    $display("t_fetch done");
  endtask
  task automatic t_size();
    logic [5:0]  kk[6] = '{6'h07, 6'h06, 6'h05, 6'h06, 6'h05, 6'h03};
    logic [31:0] aa[6] = '{32'h1000, 32'h1002, 32'h1003, 32'h1000, 32'h1002, 32'h1000};
    logic [7:0]  nn[6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    wr(`UBCM_OFF_CTRL, 32'h0);
    slow <= 1'b0;
    setch(8'h00, 32'h0000_1003, 32'h0, 8'h64);
    for (int i = 0; i < 6; i++) fire(kk[i], aa[i], 32'h0, 8'h00, nn[i]);
    $display("t_size done");
  endtask
  task automatic t_data();
    wr(`UBCM_OFF_CTRL, 32'h0000_0008);
    setch(8'h00, 32'h0, 32'h0, 8'h00);
    setch(8'h10, 32'h0000_2000, 32'h0, 8'h66);
    wr(`UBCM_OFF_B_VAL, 32'hffff_1234);
    wr(`UBCM_OFF_B_VMASK, 32'h0);
    fire(6'h06, 32'h0000_2000, 32'h0000_1234, 8'h00, 8'h01);
    fire(6'h06, 32'h0000_2000, 32'h0000_1235, 8'h00, 8'h00);
    fire(6'h06, 32'h0000_2004, 32'h0000_1234, 8'h00, 8'h00);
    wr(`UBCM_OFF_B_VMASK, 32'h0000_000f);
    fire(6'h06, 32'h0000_2000, 32'h0000_1235, 8'h00, 8'h01);
    wr(`UBCM_OFF_B_CYC, 32'h0000_0065);
    fire(6'h05, 32'h0000_2000, 32'h0000_12ff, 8'h00, 8'h01);
    wr(`UBCM_OFF_B_CYC, 32'h0000_0057);
    fire(6'h17, 32'h0000_2000, 32'h0000_5555, 8'h00, 8'h01);
    $display("t_data done");
  endtask
  task automatic t_seq();
    wr(`UBCM_OFF_CTRL, 32'h0000_0001);
    setch(8'h00, 32'h0000_0100, 32'h0, 8'h57);
    setch(8'h10, 32'h0000_0200, 32'h0, 8'h57);
    fire(6'h17, 32'h0000_0200, 32'h0, 8'h00, 8'h00);
    fire(6'h17, 32'h0000_0100, 32'h0, 8'h00, 8'h00);
    fire(6'h17, 32'h0000_0200, 32'h0, 8'h00, 8'h01);
    wr(`UBCM_OFF_COUNT, 32'h0000_0002);
    fire(6'h17, 32'h0000_0100, 32'h0, 8'h00, 8'h00);
    fire(6'h17, 32'h0000_0200, 32'h0, 8'h00, 8'h00);
    fire(6'h17, 32'h0000_0200, 32'h0, 8'h00, 8'h01);
    wr(`UBCM_OFF_COUNT, 32'h0000_0001);
    wr(`UBCM_OFF_B_ADDR, 32'h0000_0100);
    fire(6'h17, 32'h0000_0100, 32'h0, 8'h00, 8'h00);
    fire(6'h17, 32'h0000_0100, 32'h0, 8'h00, 8'h00);
    wr(`UBCM_OFF_CTRL, 32'h0000_0040);
    fire(6'h17, ~32'h0000_0100, 32'h0, 8'h00, 8'h01);
    fire(6'h17, 32'h0000_0100, 32'h0, 8'h00, 8'h00);
    $display("t_seq done");
  endtask
  task automatic t_merge();
    wr(`UBCM_OFF_CTRL, 32'h0);
    wr(`UBCM_OFF_FLAGS, 32'h0);
    setch(8'h00, 32'h0000_0300, 32'h0, 8'h57);
    setch(8'h10, 32'h0000_2000, 32'h0, 8'h6b);
    slow <= 1'b1;
    n0 = taken;
    cyc(6'h0f, 32'h0000_2000, 32'h0, 8'h00);
    @(posedge clk_i);
    cyc(6'h17, 32'h0000_0300, 32'h0, 8'h00);
    repeat (8) @(posedge clk_i);
    check(taken - n0, 8'h01);
    rdr(`UBCM_OFF_FLAGS);
    check(rd[3:0], 4'h3);
    // post-execution break on a branch whose delay slot refuses it
    wr(`UBCM_OFF_CTRL, 32'h0000_0002);
    slot <= 1'b1;
    fire(6'h17, 32'h0000_0300, 32'h0, 8'h00, 8'h00);
    check(brk_req_o, 1'b0);
    slot <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(taken - n0, 8'h01);
    $display("t_merge done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_fetch();
    t_size();
    t_data();
    t_seq();
    t_merge();
    conclude();
  end
endmodule
